/* File: daq_regs_pkg.sv */
// Purpose: Shared offsets, field positions, reset values and carriers
// Assumes: Registers are 32-bit words at byte offsets from the card base
// Notes: Narrow registers sit in the low bits; upper bits read as zero

package daq_regs_pkg;

	// ----------------------------------------
	// Register byte offsets
	// ----------------------------------------
	localparam logic [7:0] OFF_TIMER0 = 8'h00;
	localparam logic [7:0] OFF_TIMER1 = 8'h04;
	localparam logic [7:0] OFF_TIMER2 = 8'h08;
	localparam logic [7:0] OFF_TIMER_CTRL = 8'h0c;
	localparam logic [7:0] OFF_CONV_DATA = 8'h10;
	localparam logic [7:0] OFF_STATUS = 8'h18;
	localparam logic [7:0] OFF_DIGITAL = 8'h1c;
	localparam logic [7:0] OFF_KICK = 8'h20;
	localparam logic [7:0] OFF_CHAN_GAIN = 8'h24;
	localparam logic [7:0] OFF_BURST_LEN = 8'h28;
	localparam logic [7:0] OFF_SCAN_CTRL = 8'h2c;
	localparam logic [7:0] OFF_FUNCTION = 8'h30;
	localparam logic [7:0] OFF_FIFO_FLUSH = 8'h34;
	localparam logic [7:0] OFF_IRQ = 8'h38;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int BIT_READY = 0;
	localparam int BIT_OVERRUN = 1;
	localparam int BIT_OVERSPEED = 2;
	localparam int BIT_BURST_OVR = 3;
	localparam int BIT_DIGITAL_TRIGGER_IRQ_ENABLE_SEEN = 4;
	localparam int BIT_ABOUT_DONE = 5;
	localparam int BIT_NOT_EMPTY = 6;
	localparam int BIT_NOT_HALF = 7;
	localparam int BIT_NOT_FULL = 8;
	localparam int BIT_QUEUE_ALLOW = 0;
	localparam int BIT_QUEUE_CLEAR = 1;
	localparam int DIO_IN_LSB = 0;
	localparam int DIO_OUT_LSB = 4;
	localparam int CG_INT_LSB = 0;
	localparam int CG_EXT_LSB = 4;
	localparam int CG_GAIN_LSB = 8;
	localparam int IRQ_DIGITAL_TRIGGER_IRQ_ENABLE = 0;
	localparam int IRQ_HALF = 1;
	localparam int IRQ_ABOUT = 2;
	localparam int IRQ_TIMER = 3;

	// ----------------------------------------
	// Widths and reset values
	// ----------------------------------------
	localparam int DIO_W = 4;
	localparam int IRQ_W = 4;
	localparam int FIFO_DEPTH_DEF = 1024;
	localparam logic [3:0] DOUT_RST = 4'h0;
	localparam logic [7:0] BURST_RST = 8'h00;
	localparam logic [1:0] SCAN_RST = 2'h0;
	localparam logic [3:0] IRQ_EN_RST = 4'h0;
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

	// Gain codes
	typedef enum logic [1:0] {
		GAIN_X1 = 2'h0,
		GAIN_X10 = 2'h1,
		GAIN_X100 = 2'h2,
		GAIN_X1000 = 2'h3
	} gain_code_type;

	// Function register layout, bit 7 first
	typedef struct packed {
		logic digital_trigger_polarity;
		logic external_trigger_polarity;
		logic burst_simul_hold;
		logic burst_select;
		logic burst_run;
		logic post_trigger_mode;
		logic about_trigger_mode;
		logic trigger_start;
	} function_type;

	// One channel/gain queue entry, bit 9 first
	typedef struct packed {
		gain_code_type gain;
		logic [3:0] external_mux_select;
		logic [3:0] internal_mux_select;
	} chan_gain_type;

	// Converter events, each a one-cycle pulse
	typedef struct packed {
		logic conversion_done;
		logic conversion_overrun;
		logic conversion_overspeed;
		logic burst_overrun;
		logic about_complete;
		logic timer_tick;
	} conv_events_type;

	// Decoded mode levels towards the converter
	typedef struct packed {
		logic burst_active;
		logic burst_setup;
		logic post_active;
		logic post_setup;
		logic about_active;
		logic about_setup;
		logic trigger_stopped;
	} mode_levels_type;

	// Interval-timer access forwarded to the timer block
	typedef struct packed {
		logic wr;
		logic rd;
		logic [1:0] sel;
		logic [7:0] wdata;
	} timer_access_type;

endpackage

/* File: daq_acquisition_control_regs.sv */
// Purpose: Host register set for a multichannel acquisition card
// Assumes: Host accesses are single-cycle strobes on the card clock
// Notes: The FIFO store and converter live outside; flags come from
//        an occupancy count kept here

`timescale 1ns/1ps

module daq_acquisition_control_regs #(
	parameter int FIFO_DEPTH = daq_regs_pkg::FIFO_DEPTH_DEF
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [7:0] host_addr,
	input wire logic [3:0] host_be,
	input wire logic host_wr,
	input wire logic host_rd,
	input wire logic [31:0] host_wdata,
	output logic [31:0] host_rdata,
	output logic host_rvalid,
	input wire daq_regs_pkg::conv_events_type conv_events,
	input wire logic [7:0] timer_rdata,
	output daq_regs_pkg::timer_access_type timer_access,
	input wire logic [3:0] input_pin_bits,
	input wire logic digital_trigger_pin,
	input wire logic external_trigger_pin,
	output logic [3:0] output_pin_bits,
	output logic conversion_trigger,
	output daq_regs_pkg::function_type function_bits,
	output daq_regs_pkg::mode_levels_type mode_levels,
	output logic [7:0] burst_count,
	output daq_regs_pkg::chan_gain_type queue_entry,
	output logic queue_push,
	output logic queue_clear,
	output logic fifo_reset,
	output logic [3:0] irq_pending
);
	import daq_regs_pkg::*;

	localparam int CNT_W = $clog2(FIFO_DEPTH + 1);
	localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(FIFO_DEPTH);
	localparam logic [CNT_W-1:0] CNT_HALF = CNT_W'(FIFO_DEPTH / 2);
	localparam logic [CNT_W-1:0] CNT_ZERO = '0;
	localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

	// ----------------------------------------
	// Module state
	// ----------------------------------------
	typedef struct packed {
		logic [3:0] din_s1;
		logic [3:0] din_s2;
		logic digital_trigger_irq_enable_s1;
		logic digital_trigger_irq_enable_s2;
		logic digital_trigger_irq_enable_prev;
		logic etrg_s1;
		logic etrg_s2;
		logic etrg_prev;
		logic [3:0] dout;
		function_type func;
		logic [7:0] burst;
		logic [1:0] scan;
		logic [3:0] irq_en;
		logic [3:0] pend;
		logic [CNT_W-1:0] count;
		logic ready;
		logic overrun;
		logic overspeed;
		logic burst_ovr;
		logic digital_trigger_irq_enable_seen;
		logic about_done;
		chan_gain_type entry;
		logic push;
		logic clear;
		logic flush;
		logic kick;
		timer_access_type timer;
		logic timer_rd_wait;
		logic [31:0] rdata;
		logic rvalid;
	} state_type;

	state_type s_q;
	state_type s_d;

	// Decoded strobes and helpers
	logic wr_lo;
	logic data_low_read;
	logic irq_read;
	logic digital_trigger_irq_enable_edge;
	logic etrg_edge;
	logic fifo_in;
	logic fifo_out;
	logic half_rise;
	logic [31:0] status_word;
	logic [3:0] cause;

	// ----------------------------------------
	// Strobe decode
	// ----------------------------------------
	// Stored fields other than the queue entry live in byte lane 0, so a write must enable it
	assign wr_lo = host_wr && host_be[0];
	assign data_low_read = host_rd && host_be[0]
		&& host_addr == OFF_CONV_DATA;
	assign irq_read = host_rd && host_addr == OFF_IRQ;

	// Edge detect on the synchronised trigger pins, polarity selectable
	assign digital_trigger_irq_enable_edge = s_q.func.digital_trigger_polarity ?
		(s_q.digital_trigger_irq_enable_s2 && !s_q.digital_trigger_irq_enable_prev) :
		(!s_q.digital_trigger_irq_enable_s2 && s_q.digital_trigger_irq_enable_prev);
	assign etrg_edge = s_q.func.external_trigger_polarity ?
		(s_q.etrg_s2 && !s_q.etrg_prev) :
		(!s_q.etrg_s2 && s_q.etrg_prev);

	// FIFO occupancy moves; a push into a full FIFO is lost upstream
	assign fifo_in = conv_events.conversion_done && s_q.count != CNT_FULL;
	assign fifo_out = data_low_read && s_q.count != CNT_ZERO;

	// Status word, flags for the FIFO are active low
	always_comb begin
		status_word = WORD_ZERO;
		status_word[BIT_NOT_FULL] = s_q.count != CNT_FULL;
		status_word[BIT_NOT_HALF] = s_q.count < CNT_HALF;
		status_word[BIT_NOT_EMPTY] = s_q.count != CNT_ZERO;
		status_word[BIT_ABOUT_DONE] = s_q.about_done;
		status_word[BIT_DIGITAL_TRIGGER_IRQ_ENABLE_SEEN] = s_q.digital_trigger_irq_enable_seen;
		status_word[BIT_BURST_OVR] = s_q.burst_ovr;
		status_word[BIT_OVERSPEED] = s_q.overspeed;
		status_word[BIT_OVERRUN] = s_q.overrun;
		status_word[BIT_READY] = s_q.ready;
	end

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	always_comb begin
		s_d = s_q;
		half_rise = 1'b0;
		cause = '0;
		// One-cycle strobes fall back every cycle
		s_d.push = 1'b0;
		s_d.clear = 1'b0;
		s_d.flush = 1'b0;
		s_d.kick = 1'b0;
		s_d.timer.wr = 1'b0;
		s_d.timer.rd = 1'b0;
		s_d.rvalid = 1'b0;
		s_d.timer_rd_wait = 1'b0;

		// Two-stage synchronisers for pins
		s_d.din_s1 = input_pin_bits;
		s_d.din_s2 = s_q.din_s1;
		s_d.digital_trigger_irq_enable_s1 = digital_trigger_pin;
		s_d.digital_trigger_irq_enable_s2 = s_q.digital_trigger_irq_enable_s1;
		s_d.digital_trigger_irq_enable_prev = s_q.digital_trigger_irq_enable_s2;
		s_d.etrg_s1 = external_trigger_pin;
		s_d.etrg_s2 = s_q.etrg_s1;
		s_d.etrg_prev = s_q.etrg_s2;

		// Register writes
		if (host_wr) begin
			case (host_addr)
				OFF_TIMER0, OFF_TIMER1, OFF_TIMER2, OFF_TIMER_CTRL: begin
					if (host_be[0]) begin
						s_d.timer.wr = 1'b1;
						s_d.timer.sel = host_addr[3:2];
						s_d.timer.wdata = host_wdata[7:0];
					end
				end
				OFF_DIGITAL: begin
					if (wr_lo) begin
						s_d.dout = host_wdata[DIO_W-1:0];
					end
				end
				OFF_KICK: begin
					s_d.kick = 1'b1;
				end
				OFF_CHAN_GAIN: begin
					// Lane 1 carries the gain; the entry is taken whatever the byte enables
					if (s_q.scan[BIT_QUEUE_ALLOW]
						&& !s_q.scan[BIT_QUEUE_CLEAR]) begin
						s_d.entry.external_mux_select =
							host_wdata[CG_EXT_LSB +: 4];
						s_d.entry.internal_mux_select =
							host_wdata[CG_INT_LSB +: 4];
						s_d.entry.gain =
							gain_code_type'(host_wdata[CG_GAIN_LSB +: 2]);
						s_d.push = 1'b1;
					end
				end
				OFF_BURST_LEN: begin
					if (wr_lo) begin
						s_d.burst = host_wdata[7:0];
					end
				end
				OFF_SCAN_CTRL: begin
					if (wr_lo) begin
						s_d.scan = host_wdata[1:0];
						s_d.clear = host_wdata[BIT_QUEUE_CLEAR];
					end
				end
				OFF_FUNCTION: begin
					if (wr_lo) begin
						s_d.func = function_type'(host_wdata[7:0]);
						s_d.about_done = 1'b0;
					end
				end
				OFF_FIFO_FLUSH: begin
					s_d.flush = 1'b1;
				end
				OFF_IRQ: begin
					if (wr_lo) begin
						s_d.irq_en = host_wdata[IRQ_W-1:0];
					end
				end
				default: begin
				end
			endcase
		end

		// FIFO count; flush wins, then arrivals count again
		if (s_q.flush) begin
			s_d.count = CNT_ZERO;
		end else if (fifo_in && !fifo_out) begin
			s_d.count = s_q.count + CNT_ONE;
		end else if (fifo_out && !fifo_in) begin
			s_d.count = s_q.count - CNT_ONE;
		end
		half_rise = s_d.count >= CNT_HALF && s_q.count < CNT_HALF;

		// Ready flag: a new result wins over the clearing read
		if (data_low_read) begin
			s_d.ready = 1'b0;
		end
		if (conv_events.conversion_done) begin
			s_d.ready = 1'b1;
		end

		// Error flags clear on flush; an event in that cycle wins
		if (s_q.flush) begin
			s_d.overrun = 1'b0;
			s_d.overspeed = 1'b0;
			s_d.burst_ovr = 1'b0;
			s_d.digital_trigger_irq_enable_seen = 1'b0;
		end
		if (conv_events.conversion_overrun) begin
			s_d.overrun = 1'b1;
		end
		if (conv_events.conversion_overspeed) begin
			s_d.overspeed = 1'b1;
		end
		if (conv_events.burst_overrun) begin
			s_d.burst_ovr = 1'b1;
		end
		if (digital_trigger_irq_enable_edge) begin
			s_d.digital_trigger_irq_enable_seen = 1'b1;
		end
		if (conv_events.about_complete) begin
			s_d.about_done = 1'b1;
		end

		// Pending causes clear on read; new enabled causes win
		cause[IRQ_TIMER] = conv_events.timer_tick;
		cause[IRQ_ABOUT] = conv_events.about_complete;
		cause[IRQ_HALF] = half_rise;
		cause[IRQ_DIGITAL_TRIGGER_IRQ_ENABLE] = digital_trigger_irq_enable_edge;
		if (irq_read) begin
			s_d.pend = '0;
		end
		s_d.pend = s_d.pend | (cause & s_q.irq_en);

		// Read path; timer reads wait one cycle for the timer reply
		if (host_rd) begin
			s_d.rvalid = 1'b1;
			case (host_addr)
				OFF_TIMER0, OFF_TIMER1, OFF_TIMER2: begin
					s_d.rvalid = 1'b0;
					s_d.timer.rd = 1'b1;
					s_d.timer.sel = host_addr[3:2];
					s_d.timer_rd_wait = 1'b1;
				end
				OFF_STATUS: begin
					s_d.rdata = status_word;
				end
				OFF_DIGITAL: begin
					s_d.rdata = WORD_ZERO;
					s_d.rdata[DIO_OUT_LSB +: DIO_W] = s_q.dout;
					s_d.rdata[DIO_IN_LSB +: DIO_W] = s_q.din_s2;
				end
				OFF_IRQ: begin
					s_d.rdata = {28'h000_0000, s_q.pend};
				end
				default: begin
					s_d.rdata = WORD_ZERO;
				end
			endcase
		end
		if (s_q.timer_rd_wait) begin
			s_d.rdata = {24'h00_0000, timer_rdata};
			s_d.rvalid = 1'b1;
		end
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
			s_q.dout <= DOUT_RST;
			s_q.burst <= BURST_RST;
			s_q.scan <= SCAN_RST;
			s_q.irq_en <= IRQ_EN_RST;
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// Software kick and the external edge share one trigger line
	assign conversion_trigger = s_q.kick || etrg_edge;
	assign host_rdata = s_q.rdata;
	assign host_rvalid = s_q.rvalid;
	assign timer_access = s_q.timer;
	assign output_pin_bits = s_q.dout;
	assign function_bits = s_q.func;
	assign burst_count = s_q.burst;
	assign queue_entry = s_q.entry;
	assign queue_push = s_q.push;
	assign queue_clear = s_q.clear;
	assign fifo_reset = s_q.flush;
	assign irq_pending = s_q.pend;

	// Decoded mode levels
	assign mode_levels.burst_active =
		s_q.func.burst_select && s_q.func.burst_run;
	assign mode_levels.burst_setup =
		s_q.func.burst_select && !s_q.func.burst_run;
	assign mode_levels.post_active = s_q.func.post_trigger_mode
		&& !s_q.func.about_trigger_mode && s_q.func.trigger_start;
	assign mode_levels.post_setup = s_q.func.post_trigger_mode
		&& !s_q.func.about_trigger_mode && !s_q.func.trigger_start;
	assign mode_levels.about_active = s_q.func.about_trigger_mode
		&& !s_q.func.post_trigger_mode && s_q.func.trigger_start;
	assign mode_levels.about_setup = s_q.func.about_trigger_mode
		&& !s_q.func.post_trigger_mode && !s_q.func.trigger_start;
	assign mode_levels.trigger_stopped = !s_q.func.post_trigger_mode
		&& !s_q.func.about_trigger_mode;

endmodule // daq_acquisition_control_regs

/* File: daq_acquisition_control_regs_chk.sv */
// Purpose: Port-level assertions for the acquisition register set
// Assumes: One clock, asynchronous active-low reset
// Notes: Sees only the top ports; attached by bind below
`timescale 1ns/1ps

module daq_acquisition_control_regs_chk (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [7:0] host_addr,
	input wire logic [3:0] host_be,
	input wire logic host_wr,
	input wire logic host_rd,
	input wire logic [31:0] host_wdata,
	input wire logic host_rvalid,
	input wire daq_regs_pkg::timer_access_type timer_access,
	input wire logic [3:0] output_pin_bits,
	input wire logic conversion_trigger,
	input wire daq_regs_pkg::function_type function_bits,
	input wire daq_regs_pkg::mode_levels_type mode_levels,
	input wire logic queue_clear,
	input wire logic fifo_reset
);
	import daq_regs_pkg::*;

	// --------------------------------
	// Helpers
	// --------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	logic [31:0] wdata_q;
	logic wr_lo;
	assign wr_lo = host_wr && host_be[0];

	// Keep last write data so stored fields can be compared
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			wdata_q <= 32'h0000_0000;
		end else begin
			wdata_q <= host_wdata;
		end
	end

	// Timer read is forwarded first, answered a cycle later
	sequence s_timer_fwd;
		timer_access.rd && timer_access.sel == 2'h1;
	endsequence
	sequence s_answer;
		host_rvalid;
	endsequence

	// --------------------------------
	// Properties
	// --------------------------------
	a_timer_read: assert property (
		host_rd && host_addr == OFF_TIMER1
		|=> s_timer_fwd ##1 s_answer)
		else $error("timer read not forwarded or answered");
	a_status_answer: assert property (
		host_rd && host_addr == OFF_STATUS |=> host_rvalid)
		else $error("status read not answered");
	a_kick_pulse: assert property (
		host_wr && host_addr == OFF_KICK |=> conversion_trigger)
		else $error("kick write gave no trigger");
	a_flush_pulse: assert property (
		host_wr && host_addr == OFF_FIFO_FLUSH |=> fifo_reset)
		else $error("flush write gave no fifo reset");
	a_queue_clear: assert property (
		wr_lo && host_addr == OFF_SCAN_CTRL && host_wdata[1]
		|=> queue_clear)
		else $error("queue not cleared");
	a_dout_write: assert property (
		wr_lo && host_addr == OFF_DIGITAL
		|=> output_pin_bits == wdata_q[3:0])
		else $error("outputs differ from written bits");
	a_func_write: assert property (
		wr_lo && host_addr == OFF_FUNCTION
		|=> function_bits == wdata_q[7:0])
		else $error("function bits differ from written value");
	a_burst_decode: assert property (
		mode_levels.burst_active == (function_bits.burst_select
		&& function_bits.burst_run))
		else $error("burst run level wrong");
	a_stop_decode: assert property (
		mode_levels.trigger_stopped ==
		!(function_bits.post_trigger_mode
		|| function_bits.about_trigger_mode))
		else $error("trigger stop level wrong");

endmodule // daq_acquisition_control_regs_chk

bind daq_acquisition_control_regs daq_acquisition_control_regs_chk
	u_daq_acquisition_control_regs_chk (.sys_clk, .rst_n, .host_addr,
	.host_be, .host_wr, .host_rd, .host_wdata, .host_rvalid, .timer_access,
	.output_pin_bits, .conversion_trigger, .function_bits, .mode_levels,
	.queue_clear, .fifo_reset);

/* File: daq_acquisition_control_regs_tb.sv */
// Purpose: Self-checking bench for the acquisition register set
// Assumes: FIFO depth shrunk to 8 so half and full are reachable
// Notes: Single-cycle host strobes; expectations from field layout
`timescale 1ns/1ps

module daq_acquisition_control_regs_tb;
	import daq_regs_pkg::*;

	// --------------------------------
	// Signals
	// --------------------------------
	localparam int DEPTH = 8;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] host_addr = 8'h00;
	logic [3:0] host_be = 4'hf;
	logic external_trigger_pin = 1'b0;
	logic host_wr = 1'b0;
	logic host_rd = 1'b0;
	logic [31:0] host_wdata = 32'h0000_0000;
	logic [31:0] host_rdata;
	logic host_rvalid;
	conv_events_type conv_events = '0;
	timer_access_type timer_access;
	logic [3:0] input_pin_bits = 4'ha;
	logic digital_trigger_pin = 1'b0;
	logic [3:0] output_pin_bits;
	logic conversion_trigger;
	function_type function_bits;
	mode_levels_type mode_levels;
	logic [7:0] burst_count;
	chan_gain_type queue_entry;
	logic queue_push;
	logic queue_clear;
	logic fifo_reset;
	logic [3:0] irq_pending;
	int num_errors = 0;
	int comparisons = 0;
	// Last entry leaves the digital trigger positive
	logic [7:0] fn_val [8] = '{8'h90, 8'h98, 8'h84, 8'h85, 8'h82, 8'h83,
		8'he0, 8'h80};
	logic [6:0] fn_lvl [8] = '{7'h21, 7'h41, 7'h08, 7'h10, 7'h02, 7'h04,
		7'h01, 7'h01};

	// 40 MHz card clock
	always #12.5 sys_clk = ~sys_clk;

	daq_acquisition_control_regs #(.FIFO_DEPTH(DEPTH))
		u_daq_acquisition_control_regs (
		.sys_clk(sys_clk), .rst_n(rst_n), .host_addr(host_addr),
		.host_be(host_be), .host_wr(host_wr), .host_rd(host_rd),
		.host_wdata(host_wdata), .host_rdata(host_rdata),
		.host_rvalid(host_rvalid), .conv_events(conv_events),
		.timer_rdata(8'h5c), .timer_access(timer_access),
		.input_pin_bits(input_pin_bits),
		.digital_trigger_pin(digital_trigger_pin),
		.external_trigger_pin(external_trigger_pin),
		.output_pin_bits(output_pin_bits),
		.conversion_trigger(conversion_trigger),
		.function_bits(function_bits), .mode_levels(mode_levels),
		.burst_count(burst_count), .queue_entry(queue_entry),
		.queue_push(queue_push), .queue_clear(queue_clear),
		.fifo_reset(fifo_reset), .irq_pending(irq_pending));

	// --------------------------------
	// Tasks
	// --------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h expected %h",
				$time, got, exp);
		end
	endtask

	// Returns just past the edge that took the write, pulses visible
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		host_wr <= 1'b1;
		host_addr <= a;
		host_wdata <= d;
		@(posedge sys_clk);
		host_wr <= 1'b0;
		#1;
	endtask

	// Bounded wait covers the longer timer read latency
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		int n;
		@(posedge sys_clk);
		host_rd <= 1'b1;
		host_addr <= a;
		@(posedge sys_clk);
		host_rd <= 1'b0;
		#1;
		for (n = 0; n < 3 && host_rvalid !== 1'b1; n++) @(posedge sys_clk) #1;
		chk(host_rdata, exp);
	endtask

	task automatic ev(input conv_events_type e);
		@(posedge sys_clk);
		conv_events <= e;
		@(posedge sys_clk);
		conv_events <= '0;
		#1;
	endtask

	function automatic logic [31:0] st(input int n, input logic [5:0] f);
		return {23'h0, n != DEPTH, n < DEPTH / 2, n != 0, f};
	endfunction

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// --------------------------------
	// Tests
	// --------------------------------
	initial begin
		repeat (16) @(posedge sys_clk);
		rst_n <= 1'b1;
		rd(OFF_STATUS, st(0, 6'h00));
		rd(OFF_KICK, 32'h0000_0000);
		$display("test reset finished");
		for (int i = 0; i < 8; i++) begin
			wr(OFF_FUNCTION, {24'h0, fn_val[i]});
			chk(32'(function_bits), {24'h0, fn_val[i]});
			chk(32'(mode_levels), {25'h0, fn_lvl[i]});
		end
		$display("test modes finished");
		// One past full: count must saturate
		for (int i = 1; i <= DEPTH + 1; i++) begin
			ev(6'h20);
			rd(OFF_STATUS, st(i > DEPTH ? DEPTH : i, 6'h01));
		end
		rd(OFF_CONV_DATA, 32'h0000_0000);
		rd(OFF_STATUS, st(DEPTH - 1, 6'h00));
		$display("test fifo finished");
		ev(6'h1e);
		@(posedge sys_clk) digital_trigger_pin <= 1'b1;
		repeat (6) @(posedge sys_clk);
		rd(OFF_STATUS, st(DEPTH - 1, 6'h3e));
		rd(OFF_STATUS, st(DEPTH - 1, 6'h3e));
		wr(OFF_FIFO_FLUSH, 32'hdead_beef);
		chk(32'(fifo_reset), 32'h1);
		rd(OFF_STATUS, st(0, 6'h20));
		$display("test errors finished");
		wr(OFF_DIGITAL, 32'h0000_0005);
		chk(32'(output_pin_bits), 32'h5);
		rd(OFF_DIGITAL, 32'h0000_005a);
		wr(OFF_KICK, 32'h0000_0000);
		chk(32'(conversion_trigger), 32'h1);
		// Lane 0 disabled: the stored outputs must not move
		@(posedge sys_clk) host_be <= 4'he;
		wr(OFF_DIGITAL, 32'h0000_000a);
		chk(32'(output_pin_bits), 32'h5);
		@(posedge sys_clk) host_be <= 4'hf;
		// Rising external edge, seen after the two-stage sync
		wr(OFF_FUNCTION, 32'h0000_00c0);
		@(posedge sys_clk) external_trigger_pin <= 1'b1;
		repeat (2) @(posedge sys_clk);
		#1 chk(32'(conversion_trigger), 32'h1);
		@(posedge sys_clk) #1 chk(32'(conversion_trigger), 32'h0);
		wr(OFF_BURST_LEN, 32'h0000_0037);
		chk(32'(burst_count), 32'h37);
		$display("test port finished");
		rd(OFF_TIMER1, 32'h0000_005c);
		wr(OFF_TIMER_CTRL, 32'h0000_0036);
		chk(32'(timer_access), 32'h0000_0b36);
		rd(OFF_TIMER_CTRL, 32'h0000_0000);
		$display("test timer finished");
		wr(OFF_SCAN_CTRL, 32'h0000_0000);
		wr(OFF_CHAN_GAIN, 32'h0000_03a5);
		chk(32'(queue_push), 32'h0);
		wr(OFF_SCAN_CTRL, 32'h0000_0001);
		for (int g = 0; g < 4; g++) begin
			wr(OFF_CHAN_GAIN, {22'h0, 2'(g), 8'ha5});
			chk({21'h0, queue_push, queue_entry},
				{22'h1, 2'(g), 8'ha5});
		end
		wr(OFF_SCAN_CTRL, 32'h0000_0003);
		chk(32'(queue_clear), 32'h1);
		wr(OFF_CHAN_GAIN, 32'h0000_03a5);
		chk(32'(queue_push), 32'h0);
		$display("test queue finished");
		wr(OFF_IRQ, 32'h0000_0008);
		ev(6'h03);
		chk(32'(irq_pending), 32'h8);
		rd(OFF_IRQ, 32'h0000_0008);
		rd(OFF_IRQ, 32'h0000_0000);
		// All four causes enabled: ticks, half crossing, about, edge
		wr(OFF_IRQ, 32'h0000_000f);
		for (int i = 0; i < DEPTH / 2; i++) ev(6'h21);
		ev(6'h02);
		@(posedge sys_clk) digital_trigger_pin <= 1'b0;
		repeat (4) @(posedge sys_clk);
		digital_trigger_pin <= 1'b1;
		repeat (6) @(posedge sys_clk);
		rd(OFF_IRQ, 32'h0000_000f);
		$display("test irq finished");
		give_verdict();
	end

	// Tests need well under a thousand cycles
	initial begin
		repeat (3000) @(posedge sys_clk);
		num_errors++;
		give_verdict();
	end

endmodule // daq_acquisition_control_regs_tb
